/* File: verilog/output_divider_map.vh */
// register map, field positions, reset value and field codes of the
// output divider configuration block; definitions only
`ifndef OUTPUT_DIVIDER_MAP_VH
`define OUTPUT_DIVIDER_MAP_VH

// register offsets on the output page
`define OUT2_DIVIDER_HIGH 8'h20
`define OUT2_DIVIDER_MID 8'h21
`define OUT2_DIVIDER_LOW 8'h22
`define OUT2_PHASE_STRENGTH 8'h23
`define OUT2_OUTPUT_DELAY 8'h24
`define OUT2_DRIVER_SETUP 8'h25
`define OUT3_DIVIDER_HIGH 8'h28
`define OUT3_DIVIDER_MID 8'h29
`define OUT3_DIVIDER_LOW 8'h2a
`define OUT3_PHASE_STRENGTH 8'h2b
`define OUT3_OUTPUT_DELAY 8'h2c
`define OUT3_DRIVER_SETUP 8'h2d

// register slot inside one channel's group of eight offsets
`define SLOT_DIVIDER_HIGH 3'h0
`define SLOT_DIVIDER_MID 3'h1
`define SLOT_DIVIDER_LOW 3'h2
`define SLOT_PHASE_STRENGTH 3'h3
`define SLOT_OUTPUT_DELAY 3'h4
`define SLOT_DRIVER_SETUP 3'h5
`define SLOTS_PER_CHANNEL 6

// field positions
`define DIV_HIGH_MSB 3
`define DIV_HIGH_LSB 0
`define PHASE_SEL_MSB 7
`define PHASE_SEL_LSB 6
`define STRENGTH_MSB 2
`define STRENGTH_LSB 0
`define COARSE_DELAY_MSB 5
`define COARSE_DELAY_LSB 0
`define FINE_DELAY_MSB 7
`define FINE_DELAY_LSB 6
`define SUPPLY_MSB 4
`define SUPPLY_LSB 3
`define DRIVER_MSB 2
`define DRIVER_LSB 0

// reset value of every configuration byte
`define CFG_RESET 8'h00

// phase select codes
`define PHASE_TRUE_INV 2'h0
`define PHASE_TRUE_TRUE 2'h1

// supply level codes
`define SUPPLY_1V8 2'h0
`define SUPPLY_2V5 2'h1
`define SUPPLY_3V3 2'h2

// driver standard codes
`define DRV_LVDS 3'h0
`define DRV_LVPECL_CM 3'h1
`define DRV_CML 3'h2
`define DRV_HCSL 3'h3
`define DRV_LVDS_BOOST 3'h4
`define DRV_LVPECL_NOCM 3'h5

// fine delay step, picoseconds
`define FINE_STEP_PS 7'd30

`endif

/* File: verilog/config_bank.v */
// bank of configuration bytes, held in flip-flops and addressed by index
// assumes one clock, asynchronous active-low reset, one write port
`timescale 1ns/1ps
`default_nettype none
`include "output_divider_map.vh"

module config_bank
#(
    parameter ENTRIES = 12
)
(
    // clock and reset
    input wire mclk_i,
    input wire reset_n_i,
    // byte write
    input wire wr_en_i,
    input wire [3:0] wr_idx_i,
    input wire [7:0] wr_data_i,
    // whole-bank load
    input wire load_en_i,
    input wire [8*ENTRIES-1:0] load_data_i,
    // contents
    output wire [8*ENTRIES-1:0] data_o
);

    genvar i;
    generate
        for (i = 0; i < ENTRIES; i = i + 1)
        begin : entry
            reg [7:0] byte_reg;
            always @(posedge mclk_i or negedge reset_n_i)
            begin
                if (!reset_n_i)
                    byte_reg <= `CFG_RESET;
                // a byte write in the same cycle as a bulk load wins for its byte
                else if (wr_en_i && (wr_idx_i == i))
                    byte_reg <= wr_data_i;
                else if (load_en_i)
                    byte_reg <= load_data_i[8*i+7:8*i];
            end
            assign data_o[8*i+7:8*i] = byte_reg;
        end
    endgenerate

endmodule

`default_nettype wire

/* File: verilog/output_divider_config.v */
// configuration registers and clock datapath of output channels 2 and 3
// assumes register strobes and the clock are synchronous to mclk_i, which
// stands in for the channel's vco-derived clock
//
// How it works
// R01: divider value is high nibble, mid byte, low byte of three registers.
// R02: phase select 00 true/inverted, 01 true on both, 1x inverted on both.
// R03: software should program single-ended strength to seven.
// R04: delay bits 5:0 delay the output by 0 to 63 whole clock periods.
// R05: delay bits 7:6 add code times 30 ps fine delay.
// R06: supply field 00 is 1.8 V, 01 is 2.5 V, 10 is 3.3 V.
// R07: driver field selects LVDS, LVPECL, CML, HCSL, boosted LVDS, LVPECL2.
// R08: every output-page register has a non-volatile shadow copy with same layout; here the shadow bank is flip-flops cleared by reset.
// R09: fields reset to zero, read back as written; spare bits do nothing.
`timescale 1ns/1ps
`default_nettype none
`include "output_divider_map.vh"

module output_divider_config
#(
    parameter CHANNELS = 2,
    parameter DIV_WIDTH = 20,
    parameter MAX_COARSE = 63
)
(
    // clock and reset
    input wire mclk_i,
    input wire reset_n_i,
    // register access
    input wire [7:0] reg_addr_i,
    input wire reg_wr_i,
    input wire reg_rd_i,
    input wire [7:0] reg_wdata_i,
    input wire reg_shadow_i,
    output wire [7:0] reg_rdata_o,
    // shadow copy control
    input wire shadow_save_i,
    input wire shadow_load_i,
    // output 2 pads and driver settings
    output wire out2_pos_pad_o,
    output wire out2_neg_pad_o,
    output wire [2:0] out2_strength_o,
    output wire [6:0] out2_fine_delay_ps_o,
    output wire [1:0] out2_supply_level_select_o,
    output wire out2_supply_valid_o,
    output wire [2:0] out2_driver_standard_o,
    output wire out2_driver_valid_o,
    // output 3 pads and driver settings
    output wire out3_pos_pad_o,
    output wire out3_neg_pad_o,
    output wire [2:0] out3_strength_o,
    output wire [6:0] out3_fine_delay_ps_o,
    output wire [1:0] out3_supply_level_select_o,
    output wire out3_supply_valid_o,
    output wire [2:0] out3_driver_standard_o,
    output wire out3_driver_valid_o
);

    localparam ENTRIES = CHANNELS * `SLOTS_PER_CHANNEL;

    wire [8*ENTRIES-1:0] live_bytes;
    wire [8*ENTRIES-1:0] shadow_bytes;
    reg [3:0] idx;
    reg hit;
    reg [7:0] rdata_reg;
    reg [7:0] rdata_next;

    // address decode: channel 2 at 20h-25h, channel 3 at 28h-2dh
    // a plain list of offsets keeps the holes at 26h-27h and 2eh-2fh unmapped
    always @*
    begin
        idx = 4'h0;
        hit = 1'b1;
        case (reg_addr_i)
            `OUT2_DIVIDER_HIGH: idx = 4'h0;
            `OUT2_DIVIDER_MID: idx = 4'h1;
            `OUT2_DIVIDER_LOW: idx = 4'h2;
            `OUT2_PHASE_STRENGTH: idx = 4'h3;
            `OUT2_OUTPUT_DELAY: idx = 4'h4;
            `OUT2_DRIVER_SETUP: idx = 4'h5;
            `OUT3_DIVIDER_HIGH: idx = 4'h6;
            `OUT3_DIVIDER_MID: idx = 4'h7;
            `OUT3_DIVIDER_LOW: idx = 4'h8;
            `OUT3_PHASE_STRENGTH: idx = 4'h9;
            `OUT3_OUTPUT_DELAY: idx = 4'ha;
            `OUT3_DRIVER_SETUP: idx = 4'hb;
            default: hit = 1'b0;
        endcase
    end

    // live settings; a shadow load restores the whole page at once, except a byte written live in the same cycle
    config_bank #(
        .ENTRIES(ENTRIES)
    ) live_bank (
        .mclk_i(mclk_i),
        .reset_n_i(reset_n_i),
        .wr_en_i(reg_wr_i && hit && !reg_shadow_i), // [R09]
        .wr_idx_i(idx),
        .wr_data_i(reg_wdata_i),
        .load_en_i(shadow_load_i),
        .load_data_i(shadow_bytes),
        .data_o(live_bytes)
    );

    // shadow copy with the same layout, in flip-flops cleared by reset_n_i like the live bank
    config_bank #(
        .ENTRIES(ENTRIES)
    ) nonvolatile_shadow (
        .mclk_i(mclk_i),
        .reset_n_i(reset_n_i),
        .wr_en_i(reg_wr_i && hit && reg_shadow_i), // [R08]
        .wr_idx_i(idx),
        .wr_data_i(reg_wdata_i),
        .load_en_i(shadow_save_i),
        .load_data_i(live_bytes),
        .data_o(shadow_bytes)
    );

    // read data is registered; all eight bits read back, spares included
    // a read and a write in one cycle return the byte as it was before the write
    always @*
    begin
        rdata_next = rdata_reg;
        if (reg_rd_i)
        begin
            if (!hit)
                rdata_next = 8'h00;
            else if (reg_shadow_i)
                rdata_next = shadow_bytes[8*idx +: 8]; // [R08]
            else
                rdata_next = live_bytes[8*idx +: 8]; // [R09]
        end
    end

    always @(posedge mclk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            rdata_reg <= 8'h00;
        else
            rdata_reg <= rdata_next;
    end

    assign reg_rdata_o = rdata_reg;

    // per-channel datapath
    wire [CHANNELS-1:0] pos_pad;
    wire [CHANNELS-1:0] neg_pad;
    wire [3*CHANNELS-1:0] strength;
    wire [7*CHANNELS-1:0] fine_ps;
    wire [2*CHANNELS-1:0] supply;
    wire [CHANNELS-1:0] supply_ok;
    wire [3*CHANNELS-1:0] driver;
    wire [CHANNELS-1:0] driver_ok;

    genvar c;
    generate
        for (c = 0; c < CHANNELS; c = c + 1)
        begin : chan
            wire [7:0] div_high =
                live_bytes[8*(`SLOTS_PER_CHANNEL*c+`SLOT_DIVIDER_HIGH) +: 8];
            wire [7:0] div_mid =
                live_bytes[8*(`SLOTS_PER_CHANNEL*c+`SLOT_DIVIDER_MID) +: 8];
            wire [7:0] div_low =
                live_bytes[8*(`SLOTS_PER_CHANNEL*c+`SLOT_DIVIDER_LOW) +: 8];
            wire [7:0] phase_strength =
                live_bytes[8*(`SLOTS_PER_CHANNEL*c+`SLOT_PHASE_STRENGTH) +: 8];
            wire [7:0] output_delay =
                live_bytes[8*(`SLOTS_PER_CHANNEL*c+`SLOT_OUTPUT_DELAY) +: 8];
            wire [7:0] driver_setup =
                live_bytes[8*(`SLOTS_PER_CHANNEL*c+`SLOT_DRIVER_SETUP) +: 8];

            // spare nibble of the high byte is not part of the value
            // the three bytes land on separate writes, so between them the
            // divider briefly runs at a mixed value
            wire [DIV_WIDTH-1:0] output_divider_value =
                {div_high[`DIV_HIGH_MSB:`DIV_HIGH_LSB], div_mid, div_low}; // [R01]
            wire [DIV_WIDTH-1:0] high_len =
                output_divider_value - (output_divider_value >> 1);
            wire [5:0] output_skew_setting =
                output_delay[`COARSE_DELAY_MSB:`COARSE_DELAY_LSB];
            wire [1:0] fine_code = output_delay[`FINE_DELAY_MSB:`FINE_DELAY_LSB];
            wire [1:0] phase_sel = phase_strength[`PHASE_SEL_MSB:`PHASE_SEL_LSB];

            reg [DIV_WIDTH-1:0] cnt_reg;
            reg div_clk_reg;
            reg [MAX_COARSE-1:0] hist_reg;
            reg pos_reg;
            reg neg_reg;
            reg [6:0] fine_reg;
            wire true_clock;
            wire inverted_clock;

            // divide by the 20-bit value; below two the output is parked low
            always @(posedge mclk_i or negedge reset_n_i)
            begin
                if (!reset_n_i)
                begin
                    cnt_reg <= {DIV_WIDTH{1'b0}};
                    div_clk_reg <= 1'b0;
                end
                else if (output_divider_value < 2)
                begin
                    cnt_reg <= {DIV_WIDTH{1'b0}};
                    div_clk_reg <= 1'b0;
                end
                else
                begin
                    // a smaller value written mid-period wraps at once
                    if (cnt_reg >= output_divider_value - 1'b1) // [R01]
                        cnt_reg <= {DIV_WIDTH{1'b0}};
                    else
                        cnt_reg <= cnt_reg + 1'b1;
                    div_clk_reg <= (cnt_reg >= output_divider_value - 1'b1) ||
                        (cnt_reg + 1'b1 < high_len);
                end
            end

            // a full 63-stage history costs flip-flops but keeps every tap exact
            // coarse delay line: one tap per whole clock period
            always @(posedge mclk_i or negedge reset_n_i)
            begin
                if (!reset_n_i)
                    hist_reg <= {MAX_COARSE{1'b0}};
                else
                    hist_reg <= {hist_reg[MAX_COARSE-2:0], div_clk_reg};
            end

            assign true_clock = (output_skew_setting == 6'd0) ? div_clk_reg :
                hist_reg[output_skew_setting - 6'd1]; // [R04]
            assign inverted_clock = ~true_clock;

            // pad routing is registered so both pads leave on the same edge
            always @(posedge mclk_i or negedge reset_n_i)
            begin
                if (!reset_n_i)
                begin
                    pos_reg <= 1'b0;
                    neg_reg <= 1'b0;
                    fine_reg <= 7'd0;
                end
                else
                begin
                    case (phase_sel) // [R02]
                        `PHASE_TRUE_INV:
                        begin
                            pos_reg <= true_clock;
                            neg_reg <= inverted_clock;
                        end
                        `PHASE_TRUE_TRUE:
                        begin
                            pos_reg <= true_clock;
                            neg_reg <= true_clock;
                        end
                        default:
                        begin
                            pos_reg <= inverted_clock;
                            neg_reg <= inverted_clock;
                        end
                    endcase
                    // the 30 ps steps are below the clock period, so they
                    // go out as a setting for the analog delay cell
                    fine_reg <= {5'd0, fine_code} * `FINE_STEP_PS; // [R05]
                end
            end

            assign pos_pad[c] = pos_reg;
            assign neg_pad[c] = neg_reg;
            assign fine_ps[7*c +: 7] = fine_reg;
            // drive strength passes as written; seven is what software uses
            assign strength[3*c +: 3] =
                phase_strength[`STRENGTH_MSB:`STRENGTH_LSB]; // [R03]
            assign supply[2*c +: 2] = driver_setup[`SUPPLY_MSB:`SUPPLY_LSB]; // [R06]
            assign supply_ok[c] = (driver_setup[`SUPPLY_MSB:`SUPPLY_LSB] == `SUPPLY_1V8) ||
                (driver_setup[`SUPPLY_MSB:`SUPPLY_LSB] == `SUPPLY_2V5) ||
                (driver_setup[`SUPPLY_MSB:`SUPPLY_LSB] == `SUPPLY_3V3); // [R06]
            assign driver[3*c +: 3] = driver_setup[`DRIVER_MSB:`DRIVER_LSB]; // [R07]
            // codes 110 and 111 name no standard
            assign driver_ok[c] =
                (driver_setup[`DRIVER_MSB:`DRIVER_LSB] <= `DRV_LVPECL_NOCM); // [R07]
        end
    endgenerate

    assign out2_pos_pad_o = pos_pad[0];
    assign out2_neg_pad_o = neg_pad[0];
    assign out2_strength_o = strength[2:0];
    assign out2_fine_delay_ps_o = fine_ps[6:0];
    assign out2_supply_level_select_o = supply[1:0];
    assign out2_supply_valid_o = supply_ok[0];
    assign out2_driver_standard_o = driver[2:0];
    assign out2_driver_valid_o = driver_ok[0];

    assign out3_pos_pad_o = pos_pad[1];
    assign out3_neg_pad_o = neg_pad[1];
    assign out3_strength_o = strength[5:3];
    assign out3_fine_delay_ps_o = fine_ps[13:7];
    assign out3_supply_level_select_o = supply[3:2];
    assign out3_supply_valid_o = supply_ok[1];
    assign out3_driver_standard_o = driver[5:3];
    assign out3_driver_valid_o = driver_ok[1];

endmodule

`default_nettype wire

/* File: tb/output_divider_config_assertions.sv */
// port-level checker for output_divider_config
// assumes one clock domain, reset asynchronous and active low
`timescale 1ns/1ps
`default_nettype none
module output_divider_config_assertions (
    // clock and reset
    input wire logic mclk_i,
    input wire logic reset_n_i,
    // register port
    input wire logic [7:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_shadow_i,
    input wire logic [7:0] reg_rdata_o,
    // channel settings
    input wire logic [2:0] out2_strength_o,
    input wire logic [6:0] out2_fine_delay_ps_o,
    input wire logic [1:0] out2_supply_level_select_o,
    input wire logic out2_supply_valid_o,
    input wire logic [2:0] out2_driver_standard_o,
    input wire logic out2_driver_valid_o,
    input wire logic [2:0] out3_driver_standard_o
);
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!reset_n_i);
    wire live_wr = reg_wr_i && !reg_shadow_i;
    property p_drv;
        live_wr && reg_addr_i == 8'h25 |=> out2_driver_standard_o == $past(reg_wdata_i[2:0]);
    endproperty
    a_drv: assert property (p_drv) else $error("driver standard not taken from write");
    property p_sup;
        live_wr && reg_addr_i == 8'h25 |=> out2_supply_level_select_o == $past(reg_wdata_i[4:3]);
    endproperty
    a_sup: assert property (p_sup) else $error("supply level not taken from write");
    property p_drv3;
        live_wr && reg_addr_i == 8'h2d |=> out3_driver_standard_o == $past(reg_wdata_i[2:0]);
    endproperty
    a_drv3: assert property (p_drv3) else $error("out3 driver standard wrong");
    property p_str;
        live_wr && reg_addr_i == 8'h23 |=> out2_strength_o == $past(reg_wdata_i[2:0]);
    endproperty
    a_str: assert property (p_str) else $error("strength not taken from write");
    property p_fine;
        live_wr && reg_addr_i == 8'h24 |=> ##1 out2_fine_delay_ps_o == 7'd30 * $past(reg_wdata_i[7:6], 2);
    endproperty
    a_fine: assert property (p_fine) else $error("fine delay not code times step");
    property p_sval;
        out2_supply_valid_o == (out2_supply_level_select_o != 2'h3);
    endproperty
    a_sval: assert property (p_sval) else $error("supply valid flag wrong");
    property p_dval;
        out2_driver_valid_o == (out2_driver_standard_o <= 3'h5);
    endproperty
    a_dval: assert property (p_dval) else $error("driver valid flag wrong");
    property p_unmap;
        reg_rd_i && !(reg_addr_i inside {[8'h20:8'h25], [8'h28:8'h2d]}) |=> reg_rdata_o == 8'h00;
    endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
    property p_hold;
        !reg_rd_i |=> $stable(reg_rdata_o);
    endproperty
    a_hold: assert property (p_hold) else $error("read data moved without a read");
    // only whole-byte registers, so spare bits cannot blur the comparison
    property p_back;
        reg_rd_i && !reg_wr_i && $past(reg_wr_i) && !$past(reg_rd_i) &&
        ($past(reg_addr_i) inside {8'h21, 8'h22, 8'h24, 8'h29, 8'h2a, 8'h2c}) &&
        reg_addr_i == $past(reg_addr_i) && reg_shadow_i == $past(reg_shadow_i)
        |=> reg_rdata_o == $past(reg_wdata_i, 2);
    endproperty
    a_back: assert property (p_back) else $error("read back differs from write");
    c_delay_wr: cover property (live_wr && reg_addr_i == 8'h24);
    c_unmap_rd: cover property (reg_rd_i && reg_addr_i == 8'h2e);
    c_wr_rd: cover property (reg_wr_i ##1 reg_rd_i);
endmodule
bind output_divider_config output_divider_config_assertions u_output_divider_config_assertions (
    .mclk_i(mclk_i), .reset_n_i(reset_n_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i), .reg_shadow_i(reg_shadow_i),
    .reg_rdata_o(reg_rdata_o), .out2_strength_o(out2_strength_o),
    .out2_fine_delay_ps_o(out2_fine_delay_ps_o),
    .out2_supply_level_select_o(out2_supply_level_select_o),
    .out2_supply_valid_o(out2_supply_valid_o), .out2_driver_standard_o(out2_driver_standard_o),
    .out2_driver_valid_o(out2_driver_valid_o), .out3_driver_standard_o(out3_driver_standard_o)
);
`default_nettype wire

/* File: tb/output_divider_config_tb.sv */
// self-checking bench for output_divider_config against a byte-bank model
// assumes mclk_i stands in for the vco clock, stimulus on falling edges
`timescale 1ns/1ps
`default_nettype none
module output_divider_config_tb;
    logic mclk_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic [7:0] reg_addr_i = 8'h00;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic [7:0] reg_wdata_i = 8'h00;
    logic reg_shadow_i = 1'b0;
    logic shadow_save_i = 1'b0;
    logic shadow_load_i = 1'b0;
    wire [7:0] reg_rdata_o;
    wire [2:0] st[0:1], dr[0:1];
    wire [6:0] fd[0:1];
    wire [1:0] su[0:1];
    wire sv[0:1], dv[0:1], pp[0:1], np[0:1];
    logic [7:0] mem[0:1][0:255];
    logic [15:0] lfsr = 16'd68;
    logic last;
    int fail_count = 0;
    int comparisons = 0;
    int cyc = 0;
    int t0, t1, base, hp, hn, eq;
    int dl[4] = '{0, 1, 37, 63};
    initial
    begin
        forever #2.5 mclk_i = ~mclk_i;
    end
    always @(posedge mclk_i) cyc <= cyc + 1;
    output_divider_config u_output_divider_config (
        .mclk_i(mclk_i), .reset_n_i(reset_n_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
        .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i), .reg_shadow_i(reg_shadow_i),
        .reg_rdata_o(reg_rdata_o), .shadow_save_i(shadow_save_i), .shadow_load_i(shadow_load_i),
        .out2_pos_pad_o(pp[0]), .out2_neg_pad_o(np[0]), .out2_strength_o(st[0]),
        .out2_fine_delay_ps_o(fd[0]), .out2_supply_level_select_o(su[0]),
        .out2_supply_valid_o(sv[0]), .out2_driver_standard_o(dr[0]), .out2_driver_valid_o(dv[0]),
        .out3_pos_pad_o(pp[1]), .out3_neg_pad_o(np[1]), .out3_strength_o(st[1]),
        .out3_fine_delay_ps_o(fd[1]), .out3_supply_level_select_o(su[1]),
        .out3_supply_valid_o(sv[1]), .out3_driver_standard_o(dr[1]), .out3_driver_valid_o(dv[1])
    );
    function automatic logic [15:0] next_rand(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction
    function automatic bit mapped(input logic [7:0] a);
        return (a >= 8'h20 && a <= 8'h25) || (a >= 8'h28 && a <= 8'h2d);
    endfunction
    // spare bits are not promised to read back, so they are masked off
    function automatic logic [7:0] msk(input logic [7:0] a);
        return a[2:0] == 3'h0 ? 8'h0f : a[2:0] == 3'h3 ? 8'hc7 : a[2:0] == 3'h5 ? 8'h1f : 8'hff;
    endfunction
    task automatic complete_run();
        if (fail_count == 0 && comparisons > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask
    // every call drives all strobes once, so back-to-back calls never double-assign
    task automatic op(input logic w, r, input logic [7:0] a, d, input logic s, sa, ld);
        @(negedge mclk_i);
        reg_wr_i = w;
        reg_rd_i = r;
        reg_addr_i = a;
        reg_wdata_i = d;
        reg_shadow_i = s;
        shadow_save_i = sa;
        shadow_load_i = ld;
        if (sa || ld)
            for (int i = 8'h20; i < 8'h2e; i++)
                mem[sa ? 1 : 0][i] = mem[sa ? 0 : 1][i];
        if (w && mapped(a))
            mem[s][a] = d;
    endtask
    task automatic idle();
        op(0, 0, 8'h00, 8'h00, 0, 0, 0);
    endtask
    task automatic rd(input logic [7:0] a, input logic s);
        op(0, 1, a, 8'h00, s, 0, 0);
        idle();
        check("rdata", reg_rdata_o & msk(a), mapped(a) ? mem[s][a] & msk(a) : 8'h00);
    endtask
    task automatic check_all();
        for (int a = 8'h20; a < 8'h31; a++)
        begin
            rd(a[7:0], 0);
            rd(a[7:0], 1);
        end
    endtask
    task automatic outs();
        for (int c = 0; c < 2; c++)
        begin
            check("strength", st[c], mem[0][8'h23 + 8 * c][2:0]);
            check("fine", fd[c], mem[0][8'h24 + 8 * c][7:6] * 30);
            check("supply", su[c], mem[0][8'h25 + 8 * c][4:3]);
            check("supply_ok", sv[c], mem[0][8'h25 + 8 * c][4:3] != 2'h3);
            check("driver", dr[c], mem[0][8'h25 + 8 * c][2:0]);
            check("driver_ok", dv[c], mem[0][8'h25 + 8 * c][2:0] <= 3'h5);
        end
    endtask
    task automatic scramble(input int n);
        for (int i = 0; i < n; i++)
        begin
            lfsr = next_rand(lfsr);
            op(1, 0, 8'h20 + lfsr[3:0], lfsr[15:8], lfsr[4], 0, 0);
            rd(8'h20 + lfsr[3:0], lfsr[4]);
        end
    endtask
    task automatic rise_at(output int t);
        t = -1;
        last = 1'b1;
        for (int k = 0; k < 600 && t < 0; k++)
        begin
            @(negedge mclk_i);
            if (pp[0] === 1'b1 && last === 1'b0)
                t = cyc;
            last = pp[0];
        end
        if (t < 0)
        begin
            fail_count++;
            complete_run();
        end
    endtask
    initial
    begin
        foreach (mem[s, a]) mem[s][a] = 8'h00;
        repeat (12) @(posedge mclk_i);
        @(negedge mclk_i);
        reset_n_i = 1'b1;
        check_all();
        outs();
        scramble(60);
        outs();
        // save in the same cycle as a shadow write: the write must win
        op(1, 0, 8'h21, 8'ha5, 1, 1, 0);
        scramble(30);
        op(1, 0, 8'h22, 8'h3c, 0, 0, 1);
        idle();
        check_all();
        outs();
        // divider five, spare nibble set to prove it is ignored
        op(1, 0, 8'h20, 8'hf0, 0, 0, 0);
        op(1, 0, 8'h21, 8'h00, 0, 0, 0);
        op(1, 0, 8'h22, 8'h05, 0, 0, 0);
        op(1, 0, 8'h24, 8'h00, 0, 0, 0);
        for (int ph = 0; ph < 4; ph++)
        begin
            op(1, 0, 8'h23, {ph[1:0], 6'h07}, 0, 0, 0);
            repeat (8) idle();
            hp = 0;
            hn = 0;
            eq = 0;
            for (int k = 0; k < 10; k++)
            begin
                @(negedge mclk_i);
                hp += (pp[0] === 1'b1);
                hn += (np[0] === 1'b1);
                eq += (pp[0] === np[0]);
            end
            check("pos_high", hp, ph < 2 ? 6 : 4);
            check("neg_high", hn, ph == 1 ? 6 : 4);
            check("pads_equal", eq, ph == 0 ? 0 : 10);
        end
        op(1, 0, 8'h21, 8'h01, 0, 0, 0);
        op(1, 0, 8'h22, 8'h02, 0, 0, 0);
        foreach (dl[i])
        begin
            op(1, 0, 8'h24, {2'h3, dl[i][5:0]}, 0, 0, 0);
            idle();
            repeat (80) @(negedge mclk_i);
            rise_at(t0);
            rise_at(t1);
            if (i == 0)
                base = t0;
            check("period", t1 - t0, 258);
            check("skew", (t0 - base) % 258, dl[i]);
            check("fine", fd[0], 90);
        end
        reset_n_i = 1'b0;
        repeat (2) @(negedge mclk_i);
        reset_n_i = 1'b1;
        foreach (mem[s, a]) mem[s][a] = 8'h00;
        check_all();
        outs();
        // divider zero parks both channels; phase 00 puts the inverse on the negative pad
        for (int c = 0; c < 2; c++)
        begin
            check("pos_pad", pp[c], 1'b0);
            check("neg_pad", np[c], 1'b1);
        end
        complete_run();
    end
endmodule
`default_nettype wire
